// ==== mcr_consts.vh ====
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define MCR_IDX_DIR0      14'h0080
`define MCR_IDX_DIR1      14'h0090
`define MCR_IDX_DIR2      14'h00A0
`define MCR_IDX_DIR3      14'h00B0
`define MCR_IDX_CHOP      14'h2106
`define MCR_IDX_DIFF      14'h210C
`define MCR_IDX_ID_LO     14'h2300
`define MCR_IDX_ID_HI     14'h2301
`define MCR_IDX_RES_PB    14'h2450
`define MCR_IDX_RES_10    14'h2451
`define MCR_IDX_RES_8     14'h2452
`define MCR_IDX_RES_6     14'h2453
`define MCR_IDX_RES_4     14'h2454
`define MCR_IDX_RES_2     14'h2455
`define MCR_IDX_RCHOP     14'h2709

// Field positions inside each byte
`define MCR_DIR_LSB       4
`define MCR_DIR_MSB       7
`define MCR_CHOP_LSB      2
`define MCR_CHOP_MSB      3
`define MCR_DIFFA_BIT     4
`define MCR_DIFFB_BIT     5
`define MCR_RLO_LSB       0
`define MCR_RLO_MSB       2
`define MCR_RHI_LSB       4
`define MCR_RHI_MSB       6
`define MCR_RCHOP_LSB     6
`define MCR_RCHOP_MSB     7

// Reset values
`define MCR_RST_DIR       4'h0
`define MCR_RST_MODE      2'h0
`define MCR_RST_SEL       3'h0
`define MCR_RST_BYTE      8'h00

// Chopper mode encodings
`define MCR_CHOP_TOG_ACC  2'h0
`define MCR_CHOP_POS      2'h1
`define MCR_CHOP_REV      2'h2
`define MCR_CHOP_TOG      2'h3

// Pin resource selector encodings
`define MCR_RES_TMR0      3'h2
`define MCR_RES_TMR1      3'h3
`define MCR_RES_EXTERNAL_INTERRUPT_ZERO      3'h4
`define MCR_RES_EXTERNAL_INTERRUPT_ONE      3'h5

// Bus response codes
`define MCR_RESP_OKAY     2'h0
`define MCR_RESP_SLVERR   2'h2
`define MCR_RESP_DECERR   2'h3

`endif

// ==== mcr_metering_config_regs.v ====
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.vh"

// Overview of operation
// [R1] Sixteen-bit identity over two read-only bytes
// [R2] Reference chop updates only on sync rising edge
// [R3] 01 positive, 10 reversed, 11 toggles each edge
// [R4] 00 toggles except at accumulation-end edge
// [R5] Software should prefer always-toggle for low noise
// [R6] Remote chop changes every frame, any encoding
// [R7] First current input differential when bit set
// [R8] Second current input differential when bit set
// [R9] Pins two to eleven own three-bit selectors
// [R10] Selector codes: none, reserved, timers, interrupts
// [R11] Shared resource driven by OR of pins
// [R12] Sixteen direction bits, one means output
// [R13] Reserved or above five selects nothing
module mcr_metering_config_regs #(
  parameter [15:0] ID_CODE = 16'hA5C3  // Arbitrary identity value
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        multiplexer_frame_sync,
  input  wire        accumulation_end,
  input  wire [11:2] pin_level_in,
  input  wire        pushbutton_in,
  output reg         reference_chop,
  output reg         remote_chop,
  output wire        current_a_differential,
  output wire        current_b_differential,
  output wire [15:0] pin_direction,
  output reg         timer_zero_input,
  output reg         timer_one_input,
  output reg         external_interrupt_zero,
  output reg         external_interrupt_one
);

  // Number of resource selectors: pushbutton plus pins two to eleven
  localparam NSEL = 11;

  // Software-visible state
  reg [15:0]       dir_r;          // Pin direction, one per pin
  reg [1:0]        chop_mode_r;    // Reference chopper mode
  reg [1:0]        rchop_mode_r;   // Remote chopper mode
  reg              diffa_r;        // First current input differential
  reg              diffb_r;        // Second current input differential
  reg [3*NSEL-1:0] sel_r;          // Slot 0 pushbutton, slot k pin k+1

  // Write channel holding state
  reg              aw_have_r;      // Write address captured
  reg              w_have_r;       // Write data captured
  reg [13:0]       aw_idx_r;       // Captured write index
  reg [7:0]        w_byte_r;       // Captured low data byte
  reg              w_lane_r;       // Low byte lane enabled

  // Synchronisers for pins from outside the clock domain
  reg              sync_meta_r;    // Frame sync, first stage
  reg              sync_r;         // Frame sync, second stage
  reg              sync_d_r;       // Frame sync, edge history
  reg              acc_meta_r;     // Accumulation end, first stage
  reg              acc_r;          // Accumulation end, second stage
  reg [11:2]       pin_meta_r;     // Pin levels, first stage
  reg [11:2]       pin_r;          // Pin levels, second stage
  reg              pb_meta_r;      // Pushbutton, first stage
  reg              pb_r;           // Pushbutton, second stage

  wire             sync_rise;      // One-cycle frame sync edge
  wire             wr_go;          // Both halves of a write present
  wire [8:0]       rd_look;        // Read lookup: hit flag and byte
  wire [8:0]       wr_look;        // Lookup used to decode writes
  wire [NSEL-1:0]  slot_lvl;       // Synced level per selector slot

  // Read map: bit 8 is the decode hit, bits 7:0 the byte
  function [8:0] reg_read;
    input [13:0] idx;
    begin
      reg_read = {1'b1, `MCR_RST_BYTE};
      case (idx)
        // Direction nibbles ride in the upper half of the byte
        `MCR_IDX_DIR0:   reg_read[`MCR_DIR_MSB:`MCR_DIR_LSB] = dir_r[3:0];
        `MCR_IDX_DIR1:   reg_read[`MCR_DIR_MSB:`MCR_DIR_LSB] = dir_r[7:4];
        `MCR_IDX_DIR2:   reg_read[`MCR_DIR_MSB:`MCR_DIR_LSB] = dir_r[11:8];
        `MCR_IDX_DIR3:   reg_read[`MCR_DIR_MSB:`MCR_DIR_LSB] = dir_r[15:12];
        // Reference mode; other bits of the byte belong elsewhere
        `MCR_IDX_CHOP:
          reg_read[`MCR_CHOP_MSB:`MCR_CHOP_LSB] = chop_mode_r;
        // Both differential enables share one byte
        `MCR_IDX_DIFF: begin
          reg_read[`MCR_DIFFA_BIT] = diffa_r;
          reg_read[`MCR_DIFFB_BIT] = diffb_r;
        end
        // Identity bytes are constants, never state
        `MCR_IDX_ID_LO:  reg_read[7:0] = ID_CODE[7:0];   // [R1]
        `MCR_IDX_ID_HI:  reg_read[7:0] = ID_CODE[15:8];  // [R1]
        // Pushbutton selector sits alone in its byte
        `MCR_IDX_RES_PB: reg_read[`MCR_RLO_MSB:`MCR_RLO_LSB] = sel_r[2:0];
        // Selector pairs: lower pin low field, higher pin high field
        `MCR_IDX_RES_10: begin
          reg_read[`MCR_RLO_MSB:`MCR_RLO_LSB] = sel_r[29:27];
          reg_read[`MCR_RHI_MSB:`MCR_RHI_LSB] = sel_r[32:30];
        end
        `MCR_IDX_RES_8: begin
          reg_read[`MCR_RLO_MSB:`MCR_RLO_LSB] = sel_r[23:21];
          reg_read[`MCR_RHI_MSB:`MCR_RHI_LSB] = sel_r[26:24];
        end
        `MCR_IDX_RES_6: begin
          reg_read[`MCR_RLO_MSB:`MCR_RLO_LSB] = sel_r[17:15];
          reg_read[`MCR_RHI_MSB:`MCR_RHI_LSB] = sel_r[20:18];
        end
        `MCR_IDX_RES_4: begin
          reg_read[`MCR_RLO_MSB:`MCR_RLO_LSB] = sel_r[11:9];
          reg_read[`MCR_RHI_MSB:`MCR_RHI_LSB] = sel_r[14:12];
        end
        `MCR_IDX_RES_2: begin
          reg_read[`MCR_RLO_MSB:`MCR_RLO_LSB] = sel_r[5:3];
          reg_read[`MCR_RHI_MSB:`MCR_RHI_LSB] = sel_r[8:6];
        end
        // Remote mode kept for readback only
        `MCR_IDX_RCHOP:
          reg_read[`MCR_RCHOP_MSB:`MCR_RCHOP_LSB] = rchop_mode_r;
        // Unmapped index: no hit, data zero
        default: reg_read = {1'b0, `MCR_RST_BYTE};
      endcase
    end
  endfunction

  // True when a selector picks the given resource code
  function picks;
    input [2:0] sel;
    input [2:0] code;
    begin
      picks = (sel == code);
    end
  endfunction

  // Handshakes: each address or data half taken once, held till used
  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready  = ~w_have_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign rd_look = reg_read(s_axi_araddr[15:2]);
  assign wr_look = reg_read(aw_idx_r);

  // Register-backed configuration outputs
  assign current_a_differential = diffa_r;  // [R7]
  assign current_b_differential = diffb_r;  // [R8]
  assign pin_direction          = dir_r;    // [R12]

  // Write address and data capture, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_idx_r  <= 14'h0000;
      w_byte_r  <= `MCR_RST_BYTE;
      w_lane_r  <= 1'b0;
    end else begin
      // Address half
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[15:2];
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      // Data half; only lane 0 carries register bits
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Write response; identity bytes refuse writes with an error
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MCR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (!wr_look[8])
        s_axi_bresp <= `MCR_RESP_DECERR;
      else if (aw_idx_r == `MCR_IDX_ID_LO || aw_idx_r == `MCR_IDX_ID_HI)
        s_axi_bresp <= `MCR_RESP_SLVERR;  // [R1]
      else
        s_axi_bresp <= `MCR_RESP_OKAY;
    end else if (s_axi_bready) begin
      // Master has taken the answer
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register updates; a cleared lane-0 strobe leaves the byte alone
  always @(posedge aclk) begin
    if (!aresetn) begin
      dir_r        <= {4{`MCR_RST_DIR}};
      chop_mode_r  <= `MCR_RST_MODE;
      rchop_mode_r <= `MCR_RST_MODE;
      diffa_r      <= 1'b0;
      diffb_r      <= 1'b0;
      sel_r        <= {NSEL{`MCR_RST_SEL}};
    end else if (wr_go && w_lane_r) begin
      case (aw_idx_r)
        `MCR_IDX_DIR0:                                          // [R12]
          dir_r[3:0] <= w_byte_r[`MCR_DIR_MSB:`MCR_DIR_LSB];
        // Pins four to seven
        `MCR_IDX_DIR1:
          dir_r[7:4] <= w_byte_r[`MCR_DIR_MSB:`MCR_DIR_LSB];
        // Pins eight to eleven
        `MCR_IDX_DIR2:
          dir_r[11:8] <= w_byte_r[`MCR_DIR_MSB:`MCR_DIR_LSB];
        // Pins twelve to fifteen
        `MCR_IDX_DIR3:
          dir_r[15:12] <= w_byte_r[`MCR_DIR_MSB:`MCR_DIR_LSB];
        // Reference mode; acts only from the next sync edge
        `MCR_IDX_CHOP:
          chop_mode_r <= w_byte_r[`MCR_CHOP_MSB:`MCR_CHOP_LSB];
        `MCR_IDX_DIFF: begin
          diffa_r <= w_byte_r[`MCR_DIFFA_BIT];                  // [R7]
          diffb_r <= w_byte_r[`MCR_DIFFB_BIT];                  // [R8]
        end
        `MCR_IDX_RES_PB:                                        // [R9]
          sel_r[2:0] <= w_byte_r[`MCR_RLO_MSB:`MCR_RLO_LSB];
        // Pins ten and eleven
        `MCR_IDX_RES_10: begin
          sel_r[29:27] <= w_byte_r[`MCR_RLO_MSB:`MCR_RLO_LSB];
          sel_r[32:30] <= w_byte_r[`MCR_RHI_MSB:`MCR_RHI_LSB];
        end
        // Pins eight and nine
        `MCR_IDX_RES_8: begin
          sel_r[23:21] <= w_byte_r[`MCR_RLO_MSB:`MCR_RLO_LSB];
          sel_r[26:24] <= w_byte_r[`MCR_RHI_MSB:`MCR_RHI_LSB];
        end
        // Pins six and seven
        `MCR_IDX_RES_6: begin
          sel_r[17:15] <= w_byte_r[`MCR_RLO_MSB:`MCR_RLO_LSB];
          sel_r[20:18] <= w_byte_r[`MCR_RHI_MSB:`MCR_RHI_LSB];
        end
        // Pins four and five
        `MCR_IDX_RES_4: begin
          sel_r[11:9]  <= w_byte_r[`MCR_RLO_MSB:`MCR_RLO_LSB];
          sel_r[14:12] <= w_byte_r[`MCR_RHI_MSB:`MCR_RHI_LSB];
        end
        // Pins two and three
        `MCR_IDX_RES_2: begin
          sel_r[5:3] <= w_byte_r[`MCR_RLO_MSB:`MCR_RLO_LSB];
          sel_r[8:6] <= w_byte_r[`MCR_RHI_MSB:`MCR_RHI_LSB];
        end
        // Stored for readback; remote chop ignores it
        `MCR_IDX_RCHOP:
          rchop_mode_r <= w_byte_r[`MCR_RCHOP_MSB:`MCR_RCHOP_LSB];
        // Identity and unmapped: nothing stored
        default: begin
        end
      endcase
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MCR_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_look[7:0]};
      s_axi_rresp  <= rd_look[8] ? `MCR_RESP_OKAY : `MCR_RESP_DECERR;
    end else if (s_axi_rready) begin
      // Master has taken the answer
      s_axi_rvalid <= 1'b0;
    end
  end

  // Two-stage synchronisers; second stages alone feed logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta_r <= 1'b0;
      sync_r      <= 1'b0;
      sync_d_r    <= 1'b0;
      acc_meta_r  <= 1'b0;
      acc_r       <= 1'b0;
      pin_meta_r  <= 10'h000;
      pin_r       <= 10'h000;
      pb_meta_r   <= 1'b0;
      pb_r        <= 1'b0;
    end else begin
      sync_meta_r <= multiplexer_frame_sync;
      sync_r      <= sync_meta_r;
      sync_d_r    <= sync_r;
      acc_meta_r  <= accumulation_end;
      acc_r       <= acc_meta_r;
      pin_meta_r  <= pin_level_in;
      pin_r       <= pin_meta_r;
      pb_meta_r   <= pushbutton_in;
      pb_r        <= pb_meta_r;
    end
  end

  // Rising edge of the frame sync, after synchronising
  assign sync_rise = sync_r & ~sync_d_r;

  // Slot 0 pushbutton, slot k pin k+1; no out-of-range pin index
  assign slot_lvl = {pin_r, pb_r};

  // Chop states change only at a frame sync rising edge
  // Accumulation end must be held across the sync edge to be seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      reference_chop <= 1'b0;
      remote_chop    <= 1'b0;
    end else if (sync_rise) begin                               // [R2]
      // Remote chop flips every frame whatever the mode holds
      remote_chop <= ~remote_chop;                              // [R6]
      case (chop_mode_r)
        `MCR_CHOP_TOG_ACC:                                      // [R4]
          if (!acc_r)
            reference_chop <= ~reference_chop;
        `MCR_CHOP_POS: reference_chop <= 1'b0;                  // [R3]
        `MCR_CHOP_REV: reference_chop <= 1'b1;                  // [R3]
        `MCR_CHOP_TOG: reference_chop <= ~reference_chop;       // [R3]
        default:       reference_chop <= reference_chop;
      endcase
    end
  end

  // Resource routing; codes 0, 1 and 6-7 match nothing
  always @* begin : route
    integer k;
    reg     lvl;
    timer_zero_input        = 1'b0;
    timer_one_input         = 1'b0;
    external_interrupt_zero = 1'b0;
    external_interrupt_one  = 1'b0;
    lvl                     = 1'b0;
    for (k = 0; k < NSEL; k = k + 1) begin                      // [R11]
      // Level of this slot's pin, already synchronised
      lvl = slot_lvl[k];
      // Timer zero clock or gate
      if (picks(sel_r[3*k +: 3], `MCR_RES_TMR0))                // [R10]
        timer_zero_input = timer_zero_input | lvl;
      // Timer one clock or gate
      if (picks(sel_r[3*k +: 3], `MCR_RES_TMR1))
        timer_one_input = timer_one_input | lvl;
      // External interrupt zero
      if (picks(sel_r[3*k +: 3], `MCR_RES_EXTERNAL_INTERRUPT_ZERO))
        external_interrupt_zero = external_interrupt_zero | lvl;
      // External interrupt one; exact match leaves 1, 6, 7 unrouted
      if (picks(sel_r[3*k +: 3], `MCR_RES_EXTERNAL_INTERRUPT_ONE))                // [R13]
        external_interrupt_one = external_interrupt_one | lvl;
    end
  end

endmodule // mcr_metering_config_regs

`default_nettype wire

// ==== mcr_regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// Timing watcher on the bank's ports
module mcr_regs_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        multiplexer_frame_sync,
  input wire logic [11:2] pin_level_in,
  input wire logic        pushbutton_in,
  input wire logic        reference_chop,
  input wire logic        remote_chop,
  input wire logic        current_a_differential,
  input wire logic        timer_zero_input,
  input wire logic        external_interrupt_one
);
  logic [3:0] since_r; // Cycles since sync rose
  wire        any_in = |{pin_level_in, pushbutton_in}; // Any pin high
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturates so a quiet sync line never looks fresh
  always @(posedge aclk) begin
    if (!aresetn)
      since_r <= 4'hF;
    else if ($rose(multiplexer_frame_sync))
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  rd_upper_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  ref_sync_a: assert property ($changed(reference_chop) |->
    since_r < 4'h8) else $error("reference chop moved without sync");
  rem_sync_a: assert property ($changed(remote_chop) |->
    since_r < 4'h8) else $error("remote chop moved without sync");
  res_cause_a: assert property ((timer_zero_input ||
    external_interrupt_one) |-> $past(any_in, 1) || $past(any_in, 2) ||
    $past(any_in, 3)) else $error("resource high with no pin high");
  diff_write_a: assert property ($changed(current_a_differential) |->
    $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("differential enable moved without write");
  cover property ($changed(reference_chop));
  cover property ($changed(current_a_differential));
  cover property (external_interrupt_one);
endmodule // mcr_regs_chk

bind mcr_metering_config_regs mcr_regs_chk mcr_regs_chk_i (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .multiplexer_frame_sync, .pin_level_in, .pushbutton_in,
  .reference_chop, .remote_chop, .current_a_differential,
  .timer_zero_input, .external_interrupt_one);
`default_nettype wire

// ==== mcr_metering_config_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus tasks and pin stimulus for the configuration bank
module mcr_metering_config_regs_bench;
  localparam [15:0] ID     = 16'h3C5A; // Arbitrary identity value
  localparam [13:0] MODE_T = 14'h00F9; // Chop mode per step
  localparam [6:0]  ACC_T  = 7'h28;    // Interval end per step
  localparam [6:0]  REF_T  = 7'h4A;    // Reference chop per step
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, pushbutton_in = 1'h0;
  logic        multiplexer_frame_sync = 1'h0, accumulation_end = 1'h0;
  logic [11:2] pin_level_in = 10'h0;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] pin_direction;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, reference_chop, remote_chop;
  wire         current_a_differential, current_b_differential;
  wire         timer_zero_input, timer_one_input;
  wire         external_interrupt_zero, external_interrupt_one;
  wire  [3:0]  res_out = {external_interrupt_one, external_interrupt_zero,
                          timer_one_input, timer_zero_input};
  int          fail_count = 0, n_compared = 0;
  logic        rem_x = 1'h0; // Expected remote chop

  always #5 aclk = ~aclk; // 100 MHz

  mcr_metering_config_regs #(.ID_CODE(ID)) mcr_metering_config_regs_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .multiplexer_frame_sync, .accumulation_end,
    .pin_level_in, .pushbutton_in, .reference_chop, .remote_chop,
    .current_a_differential, .current_b_differential, .pin_direction,
    .timer_zero_input, .timer_one_input, .external_interrupt_zero,
    .external_interrupt_one);

  // Verdict and stop
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare and count
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Let edge updates land before looking
  task automatic tick(int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // A silent slave must not hang the run
  task automatic guard(int k);
    if (k > 40) begin
      fail_count++;
      $display("CHECK FAILED bus answer expected 1 seen 0");
      end_of_test();
    end
  endtask
  // Ready goes up only after the answer, to exercise the hold
  task automatic wr(logic [15:0] a, logic [7:0] d, logic [3:0] s,
                    logic [1:0] r);
    int k;
    logic aw, w, b, done;
    logic [1:0] br;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      done = b && s_axi_bready;
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= ~s_axi_bready;
      k++;
      guard(k);
    end while (!done);
    chk("write response", r, br);
  endtask
  // Same late-ready pattern on the read side
  task automatic rd(logic [15:0] a, logic [31:0] e, logic [1:0] r);
    int k;
    logic ar, v, done;
    logic [1:0] rr;
    logic [31:0] dd;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      dd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      done = v && s_axi_rready;
      if (ar) s_axi_arvalid <= 1'h0;
      if (v) s_axi_rready <= ~s_axi_rready;
      k++;
      guard(k);
    end while (!done);
    chk("read data", e, dd);
    chk("read response", r, rr);
  endtask
  // One sync pulse, held past the synchronizer
  task automatic frame(logic acc);
    @(posedge aclk);
    accumulation_end <= acc;
    @(posedge aclk);
    multiplexer_frame_sync <= 1'h1;
    repeat (4) @(posedge aclk);
    multiplexer_frame_sync <= 1'h0;
    tick(6);
    rem_x = ~rem_x;
    chk("remote chop", rem_x, remote_chop);
  endtask
  // Raise one pin (12 is the pushbutton), expect its resource
  task automatic try_res(int p, logic [2:0] c);
    logic [3:0] e;
    e = (c > 3'h1 && c < 3'h6) ? 4'h1 << (c - 3'h2) : 4'h0;
    @(posedge aclk);
    if (p < 12)
      pin_level_in[p] <= 1'h1;
    else
      pushbutton_in <= 1'h1;
    tick(4);
    chk("resource", e, res_out);
    @(posedge aclk);
    pin_level_in <= 10'h0;
    pushbutton_in <= 1'h0;
    tick(4);
    chk("resource idle", 32'h0, res_out);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    chk("direction", 32'h0, pin_direction);
    chk("reference chop", 32'h0, reference_chop);
    rd(16'h8C00, {24'h0, ID[7:0]}, 2'h0);
    rd(16'h8C04, {24'h0, ID[15:8]}, 2'h0);
    wr(16'h8C04, 8'h00, 4'hF, 2'h2);
    rd(16'h8C04, {24'h0, ID[15:8]}, 2'h0);
    rd(16'h0004, 32'h0, 2'h3);
    wr(16'h0004, 8'h5A, 4'hF, 2'h3);
    for (int i = 0; i < 4; i++) begin
      wr(16'h8430, 8'(i << 4), 4'hF, 2'h0);
      chk("diff a", i & 1, current_a_differential);
      chk("diff b", i >> 1, current_b_differential);
      rd(16'h8430, 32'(i << 4), 2'h0);
    end
    wr(16'h8430, 8'h00, 4'hE, 2'h0);
    chk("diff kept", 32'h1, current_b_differential);
    for (int g = 0; g < 4; g++)
      wr(16'h0200 + 16'(g * 64), 8'((g + 5) << 4), 4'hF, 2'h0);
    chk("direction", 32'h8765, pin_direction);
    wr(16'h9C24, 8'hC0, 4'hF, 2'h0);
    rd(16'h9C24, 32'hC0, 2'h0);
    for (int i = 0; i < 7; i++) begin
      wr(16'h8418, {4'h0, MODE_T[2*i +: 2], 2'h0}, 4'hF, 2'h0);
      rd(16'h8418, {28'h0, MODE_T[2*i +: 2], 2'h0}, 2'h0);
      tick(3);
      chk("chop held", i ? REF_T[i-1] : 1'h0, reference_chop);
      frame(ACC_T[i]);
      chk("reference chop", REF_T[i], reference_chop);
    end
    for (int p = 2; p < 12; p++) begin
      wr(16'h9154 - 16'((p - 2) / 2 * 4),
         8'((p % 4 + 2) << (p % 2 * 4)), 4'hF, 2'h0);
      try_res(p, 3'(p % 4 + 2));
    end
    for (int c = 0; c < 8; c++) begin
      wr(16'h9154, 8'(c), 4'hF, 2'h0);
      try_res(2, 3'(c));
    end
    wr(16'h9154, 8'h22, 4'hF, 2'h0);
    wr(16'h9140, 8'h02, 4'hF, 2'h0);
    try_res(3, 3'h2);
    try_res(12, 3'h2);
    end_of_test();
  end
endmodule // mcr_metering_config_regs_bench
`default_nettype wire
